// ### logic/psci_cmd_interp.sv
/*
  psci_cmd_interp: management-port command interpreter of a rectifier.
  Link side (link_clk) is a two-wire bus slave with pec; core side (clk)
  holds status, set points and output control.
  Assumes scl/sda arrive unsynchronised, link_clk oversamples scl well,
  and the pad ties sda low whenever sda_oe is high.
*/
`timescale 1ns/100ps
module psci_cmd_interp #(
  parameter longint OFF_CYCLES = psci_pkg::OFF_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [2:0]  addr_sel,
  input  wire logic        enable_n,
  input  wire logic [7:0]  status1_in,
  input  wire logic [7:0]  alarm1_in,
  input  wire logic [7:0]  alarm2_in,
  input  wire logic        high_line,
  input  wire logic        restart_pend,
  input  wire logic [15:0] vout_meas,
  input  wire logic [15:0] iout_amps,
  input  wire logic [15:0] temp_c,
  input  wire logic [8:0]  vin_volts,
  input  wire logic [7:0]  pin_meas,
  input  wire logic [7:0]  fan_pct,
  input  wire logic [15:0] fan_rpm,
  input  wire logic [23:0] fw_rev,
  input  wire logic [23:0] run_time,
  input  wire logic        iso_done,
  input  wire logic        iso_pass,
  output logic             alert_out_n,
  output logic             output_on,
  output logic [15:0]      vout_set,
  output logic [15:0]      overvoltage_limit_cmd,
  output logic             vout_bus_ctl,
  output logic             restart_clr,
  output logic             mfr_stb,
  output logic [7:0]       mfr_code
);
  localparam int CW = $clog2(OFF_CYCLES + 1);

  typedef enum logic [2:0] {L_IDLE, L_RX, L_RACK, L_TX, L_TACK, L_WAIT} psci_lst_t;

  // link domain state, except en_q (core domain)
  psci_lst_t   lst_reg;
  logic [2:0]  scl_q, sda_q, en_q;
  logic [2:0]  a1_reg, a2_reg;
  logic [3:0]  bitc_reg;
  logic [7:0]  sh_reg, txb_reg, crc_reg, crcp_reg, last_reg;
  logic [7:0]  cmd_reg, d0_reg, d1_reg;
  logic [4:0]  nb_reg, tj_reg;
  logic        rd_reg, acc_reg, sr_reg, ph_reg, ackv_reg, oe_reg;
  logic        ev_tgl_reg, ev_rd_reg, ev_pec_reg;
  logic [7:0]  ev_cmd_reg, ev_d0_reg, ev_d1_reg;
  logic [2:0]  ev_n_reg;
  logic [1:0]  sn_sync;
  logic        lack_reg;
  logic [7:0]  lsnap [psci_pkg::SN_N];

  // core domain state
  logic [2:0]  ev_q;
  logic [1:0]  ack_sync;
  logic        snap_tgl_reg;
  logic [7:0]  snap [psci_pkg::SN_N];
  logic        out_req_reg, pec_reg, bad_reg, isof_reg, isook_reg;
  logic        rstok_reg, range_reg, alert_reg, on_d_reg;
  logic [CW-1:0] off_cnt_reg;
  logic [28:0] wv_reg;

  logic        scl_s, sda_s, rise, fall, start_c, stop_c;
  logic [7:0]  rxb, txn;
  logic [4:0]  rl, tot;
  logic        blk;

  // synchronised pins: stage 0 feeds stage 1 only
  assign scl_s   = scl_q[1];
  assign sda_s   = sda_q[1];
  assign rise    = scl_s & ~scl_q[2];
  assign fall    = ~scl_s & scl_q[2];
  assign start_c = scl_s & scl_q[2] & sda_q[2] & ~sda_s;
  assign stop_c  = scl_s & scl_q[2] & ~sda_q[2] & sda_s;
  assign rxb     = {sh_reg[6:0], sda_s};
  assign sda_out = 1'b0; // open drain: only the enable moves
  assign sda_oe  = oe_reg;

  // link-side input synchronisers
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q  <= 3'h7;
      sda_q  <= 3'h7;
      a1_reg <= 3'h0;
      a2_reg <= 3'h0;
    end else begin
      scl_q  <= {scl_q[1:0], scl_in};
      sda_q  <= {sda_q[1:0], sda_in};
      a1_reg <= addr_sel;
      a2_reg <= a1_reg;
    end
  end

  always_comb begin
    rl  = psci_pkg::rd_len(cmd_reg);
    blk = (rl > 5'h02);
    tot = rl + {4'h0, blk};
    if (rl == 5'h00) begin
      txn = psci_pkg::NO_DATA;
    end else if (tj_reg == tot) begin
      txn = crc_reg;
    end else if (blk && tj_reg == 5'h00) begin
      txn = {3'h0, rl};
    end else begin
      txn = lsnap[5'(psci_pkg::rd_base(cmd_reg) + tj_reg - {4'h0, blk})];
    end
  end

  // bit engine and byte framing
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lst_reg  <= L_IDLE;
      bitc_reg <= 4'h0;
      sh_reg   <= 8'h00;
      txb_reg  <= 8'h00;
      crc_reg  <= 8'h00;
      crcp_reg <= 8'h00;
      last_reg <= 8'h00;
      cmd_reg  <= 8'h00;
      d0_reg   <= 8'h00;
      d1_reg   <= 8'h00;
      nb_reg   <= 5'h00;
      tj_reg   <= 5'h00;
      rd_reg   <= 1'b0;
      acc_reg  <= 1'b0;
      sr_reg   <= 1'b0;
      ph_reg   <= 1'b0;
      ackv_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else if (stop_c) begin
      lst_reg <= L_IDLE;
      acc_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (start_c) begin
      lst_reg  <= L_RX;
      bitc_reg <= 4'h0;
      oe_reg   <= 1'b0;
      sr_reg   <= acc_reg;
      if (!acc_reg) begin
        // pec restarts only on a fresh frame
        crc_reg <= 8'h00;
        nb_reg  <= 5'h00;
        rd_reg  <= 1'b0;
      end
    end else begin
      case (lst_reg)
        L_RX: if (rise) begin
          sh_reg   <= rxb;
          bitc_reg <= bitc_reg + 4'h1;
          if (bitc_reg == 4'h7) begin
            crcp_reg <= crc_reg;
            crc_reg  <= psci_pkg::crc8(crc_reg, rxb);
            last_reg <= rxb;
            lst_reg  <= L_RACK;
            ph_reg   <= 1'b0;
            if (!acc_reg) begin
              acc_reg  <= (rxb == {psci_pkg::ADDR_HI, a2_reg, 1'b0}) ||
                          (rxb == psci_pkg::BCAST_ADDR);
              ackv_reg <= (rxb == {psci_pkg::ADDR_HI, a2_reg, 1'b0}) ||
                          (rxb == psci_pkg::BCAST_ADDR);
            end else if (sr_reg) begin
              // reads are never taken on the broadcast address
              rd_reg   <= (rxb == {psci_pkg::ADDR_HI, a2_reg, 1'b1});
              ackv_reg <= (rxb == {psci_pkg::ADDR_HI, a2_reg, 1'b1});
              sr_reg   <= 1'b0;
              tj_reg   <= 5'h00;
            end else begin
              // command then data bytes, low byte first
              if (nb_reg == 5'h00) cmd_reg <= rxb;
              if (nb_reg == 5'h01) d0_reg <= rxb;
              if (nb_reg == 5'h02) d1_reg <= rxb;
              if (nb_reg != 5'h1f) nb_reg <= nb_reg + 5'h01;
              ackv_reg <= 1'b1;
            end
          end
        end
        L_RACK: if (fall) begin
          if (!ph_reg) begin
            oe_reg <= ackv_reg;
            ph_reg <= 1'b1;
          end else begin
            bitc_reg <= 4'h0;
            if (!ackv_reg) begin
              oe_reg  <= 1'b0;
              acc_reg <= 1'b0;
              lst_reg <= L_WAIT;
            end else if (rd_reg) begin
              txb_reg <= txn;
              oe_reg  <= ~txn[7];
              crc_reg <= psci_pkg::crc8(crc_reg, txn);
              tj_reg  <= tj_reg + 5'h01;
              lst_reg <= L_TX;
            end else begin
              oe_reg  <= 1'b0;
              lst_reg <= L_RX;
            end
          end
        end
        L_TX: begin
          if (rise) bitc_reg <= bitc_reg + 4'h1;
          if (fall) begin
            if (bitc_reg == 4'h8) begin
              oe_reg  <= 1'b0;
              lst_reg <= L_TACK;
            end else begin
              txb_reg <= {txb_reg[6:0], 1'b0};
              oe_reg  <= ~txb_reg[6];
            end
          end
        end
        L_TACK: begin
          if (rise) ackv_reg <= ~sda_s;
          if (fall) begin
            bitc_reg <= 4'h0;
            if (ackv_reg) begin
              txb_reg <= txn;
              oe_reg  <= ~txn[7];
              crc_reg <= psci_pkg::crc8(crc_reg, txn);
              tj_reg  <= tj_reg + 5'h01;
              lst_reg <= L_TX;
            end else begin
              lst_reg <= L_WAIT;
            end
          end
        end
        L_WAIT:  oe_reg <= 1'b0;
        default: lst_reg <= L_IDLE;
      endcase
    end
  end

  // frame result, handed to core by toggle; fields held until next frame
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_tgl_reg <= 1'b0;
      ev_rd_reg  <= 1'b0;
      ev_pec_reg <= 1'b0;
      ev_cmd_reg <= 8'h00;
      ev_d0_reg  <= 8'h00;
      ev_d1_reg  <= 8'h00;
      ev_n_reg   <= 3'h0;
    end else if (stop_c && (acc_reg || rd_reg) && nb_reg != 5'h00) begin
      ev_tgl_reg <= ~ev_tgl_reg;
      ev_rd_reg  <= rd_reg;
      ev_cmd_reg <= cmd_reg;
      ev_d0_reg  <= d0_reg;
      ev_d1_reg  <= d1_reg;
      ev_n_reg   <= (nb_reg < 5'h02) ? 3'h0 : 3'(nb_reg - 5'h02);
      // last byte checked against pec of all before it
      ev_pec_reg <= (nb_reg >= 5'h02) && (last_reg == crcp_reg);
    end
  end

  // snapshot copy, frozen while a read sends so its bytes agree
  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sn_sync  <= 2'h0;
      lack_reg <= 1'b0;
      for (int i = 0; i < psci_pkg::SN_N; i++) lsnap[i] <= 8'h00;
    end else begin
      sn_sync <= {sn_sync[0], snap_tgl_reg};
      if (sn_sync[1] != lack_reg && !(rd_reg && acc_reg)) begin
        lack_reg <= sn_sync[1];
        for (int i = 0; i < psci_pkg::SN_N; i++) lsnap[i] <= snap[i];
      end
    end
  end

  // core-side synchronisers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_q     <= 3'h0;
      ack_sync <= 2'h0;
      en_q     <= 3'h7;
    end else begin
      ev_q     <= {ev_q[1:0], ev_tgl_reg};
      ack_sync <= {ack_sync[0], lack_reg};
      en_q     <= {en_q[1:0], enable_n};
    end
  end

  logic       ev, ok_wr, clr, rd_stat, restart, op_ok, v_ok, chg;
  logic [2:0] wl;
  logic [7:0] s1v, s2v;
  logic [15:0] vreq;

  assign ev      = ev_q[1] ^ ev_q[2];
  assign wl      = psci_pkg::wr_len(ev_cmd_reg);
  assign vreq    = {ev_d1_reg, ev_d0_reg};
  // only a clean pec lets a write execute
  assign ok_wr   = ev && !ev_rd_reg && ev_pec_reg && wl != psci_pkg::WL_BAD &&
                   ev_n_reg == wl;
  assign clr     = ok_wr && ev_cmd_reg == psci_pkg::CMD_CLR;
  assign rd_stat = ev && ev_rd_reg && ev_cmd_reg == psci_pkg::CMD_STAT;
  assign op_ok   = ev_d0_reg == psci_pkg::ON_BYTE || ev_d0_reg == psci_pkg::OFF_BYTE;
  // window 42..58 v in code units
  assign v_ok    = vreq >= psci_pkg::VOUT_MIN_CODE && vreq <= psci_pkg::VOUT_MAX_CODE;
  // back on after a long enough off time
  assign restart = output_on && !on_d_reg && off_cnt_reg == CW'(OFF_CYCLES);

  // one means active; live bits mirrored
  assign s2v = {pec_reg, restart_pend, bad_reg, high_line, isof_reg, rstok_reg,
                range_reg, en_q[1]};
  assign s1v = {status1_in[7], isook_reg, status1_in[5:1], output_on};

  // output switch and bus set points
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_req_reg           <= 1'b1;
      output_on             <= 1'b0;
      on_d_reg              <= 1'b0;
      vout_set              <= 16'h0000;
      overvoltage_limit_cmd <= 16'h0000;
      vout_bus_ctl          <= 1'b0;
      mfr_stb               <= 1'b0;
      mfr_code              <= 8'h00;
    end else begin
      // on by default, gated by enable pin
      output_on <= out_req_reg & ~en_q[1];
      on_d_reg  <= output_on;
      mfr_stb   <= 1'b0;
      if (ok_wr) begin
        case (ev_cmd_reg)
          psci_pkg::CMD_OP: if (op_ok) out_req_reg <= ev_d0_reg[7];
          // in-range set point; latches bus control
          psci_pkg::CMD_VOUT: if (v_ok) begin
            vout_set     <= vreq;
            vout_bus_ctl <= 1'b1;
          end
          psci_pkg::CMD_OVLIM: overvoltage_limit_cmd <= vreq;
          psci_pkg::CMD_CLR: ;
          // maker codes passed on as a strobe
          default: begin
            mfr_stb  <= 1'b1;
            mfr_code <= ev_cmd_reg;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      off_cnt_reg <= '0;
      restart_clr <= 1'b0;
    end else begin
      restart_clr <= restart;
      if (output_on) off_cnt_reg <= '0;
      else if (off_cnt_reg != CW'(OFF_CYCLES)) off_cnt_reg <= off_cnt_reg + 1'b1;
    end
  end

  // sticky status-2 flags and iso ok: a set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pec_reg   <= 1'b0;
      bad_reg   <= 1'b0;
      isof_reg  <= 1'b0;
      isook_reg <= 1'b0;
      rstok_reg <= 1'b0;
      range_reg <= 1'b0;
    end else begin
      pec_reg   <= (ev && !ev_rd_reg && !ev_pec_reg) || (pec_reg && !clr);
      bad_reg   <= (ev && !ev_rd_reg && ev_pec_reg && !ok_wr) ||
                   (ev && ev_rd_reg && psci_pkg::rd_len(ev_cmd_reg) == 5'h00) ||
                   (bad_reg && !clr);
      isof_reg  <= (iso_done && !iso_pass) || (isof_reg && !clr);
      isook_reg <= (iso_done && iso_pass) || (isook_reg && !clr);
      // clear drops these; restart sets its own
      rstok_reg <= restart || (rstok_reg && !clr);
      // follows data validity, not the clear command
      if (ok_wr && ev_cmd_reg == psci_pkg::CMD_VOUT) range_reg <= !v_ok;
      else if (ok_wr && ev_cmd_reg == psci_pkg::CMD_OP) range_reg <= !op_ok;
    end
  end

  // alert latches on change, released by read, clear or restart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wv_reg    <= '0;
      alert_reg <= 1'b0;
    end else begin
      wv_reg    <= {status1_in, alarm1_in, alarm2_in, en_q[1], high_line,
                    restart_pend, pec_reg, bad_reg};
      // an alarm still present holds the line through a read or clear release
      alert_reg <= chg || (alert_reg && !(rd_stat || clr || restart)) ||
                   ((rd_stat || clr) && |{alarm1_in, alarm2_in});
    end
  end
  assign chg = wv_reg != {status1_in, alarm1_in, alarm2_in, en_q[1], high_line,
                          restart_pend, pec_reg, bad_reg};
  assign alert_out_n = ~alert_reg;

  // whole snapshot loaded in one clk edge, then handed over
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_tgl_reg <= 1'b0;
      for (int i = 0; i < psci_pkg::SN_N; i++) snap[i] <= 8'h00;
    end else if (ack_sync[1] == snap_tgl_reg) begin
      snap_tgl_reg <= ~snap_tgl_reg;
      snap[0]  <= s1v;
      snap[1]  <= s2v;
      snap[2]  <= alarm1_in;
      snap[3]  <= alarm2_in;
      // vout already in 400-per-volt code, low byte first
      snap[4]  <= vout_meas[7:0];
      snap[5]  <= vout_meas[15:8];
      snap[6]  <= 8'(iout_amps * psci_pkg::IOUT_M);
      snap[7]  <= 8'((iout_amps * psci_pkg::IOUT_M) >> 8);
      snap[8]  <= temp_c[7:0];
      snap[9]  <= temp_c[15:8];
      snap[10] <= 8'(vin_volts - psci_pkg::VIN_B);
      snap[11] <= pin_meas;
      snap[12] <= fw_rev[7:0];
      snap[13] <= fw_rev[15:8];
      snap[14] <= fw_rev[23:16];
      snap[15] <= run_time[7:0];
      snap[16] <= run_time[15:8];
      snap[17] <= run_time[23:16];
      snap[18] <= fan_pct;
      snap[19] <= 8'h00;
      snap[20] <= 8'(fan_rpm / psci_pkg::RPM_M);
      snap[21] <= 8'((fan_rpm / psci_pkg::RPM_M) >> 8);
    end
  end
endmodule // psci_cmd_interp

// ### logic/psci_pkg.sv
/*
  psci_pkg: constants, command codes and helper functions shared by the
  rectifier management-port command interpreter.
  Assumes a 200 MHz core clock and an SMBus-style two-wire link.
*/
package psci_pkg;
  localparam int          CLK_HZ        = 200_000_000;
  localparam int          RESTART_OFF_S = 2;
  localparam longint      OFF_CYC       = longint'(RESTART_OFF_S) * longint'(CLK_HZ);
  localparam logic [3:0]  ADDR_HI       = 4'h8;
  localparam logic [7:0]  BCAST_ADDR    = 8'h00;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  ON_BYTE       = 8'h80;
  localparam logic [7:0]  OFF_BYTE      = 8'h00;
  localparam logic [7:0]  NO_DATA       = 8'hff;
  // command codes
  localparam logic [7:0]  CMD_OP        = 8'h01;
  localparam logic [7:0]  CMD_CLR       = 8'h03;
  localparam logic [7:0]  CMD_VOUT      = 8'h21;
  localparam logic [7:0]  CMD_OVLIM     = 8'h40;
  localparam logic [7:0]  CMD_STAT      = 8'hd0;
  localparam logic [7:0]  CMD_MFR_LO    = 8'hd2;
  localparam logic [7:0]  CMD_ISO       = 8'hda;
  localparam logic [7:0]  CMD_VIN       = 8'hdc;
  localparam logic [7:0]  CMD_FWREV     = 8'hdd;
  localparam logic [7:0]  CMD_RUNT      = 8'hde;
  localparam logic [7:0]  CMD_FANSET    = 8'hdf;
  localparam logic [7:0]  CMD_FAN       = 8'he1;
  localparam logic [7:0]  CMD_MFR_HI    = 8'he2;
  localparam logic [2:0]  WL_BAD        = 3'h7;
  // direct-mode coefficients
  localparam int          VOUT_M        = 400;
  localparam int          VOUT_MIN_V    = 42;
  localparam int          VOUT_MAX_V    = 58;
  localparam logic [15:0] VOUT_MIN_CODE = 16'(VOUT_MIN_V * VOUT_M);
  localparam logic [15:0] VOUT_MAX_CODE = 16'(VOUT_MAX_V * VOUT_M);
  localparam logic [15:0] IOUT_M        = 16'h0005;
  localparam logic [8:0]  VIN_B         = 9'h04b;
  localparam logic [15:0] RPM_M         = 16'h0064;
  // status-2 and status-1 bit positions
  localparam int S2_PEC = 7, S2_WREST = 6, S2_BAD = 5, S2_HLINE = 4;
  localparam int S2_ISOF = 3, S2_RSTOK = 2, S2_RANGE = 1, S2_ENHI = 0;
  localparam int S1_ISOOK = 6;
  // snapshot byte map
  localparam logic [4:0]  SN_STAT = 5'h00, SN_VIN = 5'h0a, SN_FW = 5'h0c;
  localparam logic [4:0]  SN_RUNT = 5'h0f, SN_FAN = 5'h12;
  localparam int          SN_N    = 22;

  // smbus pec, x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // data bytes of a write command, WL_BAD when not writable
  function automatic logic [2:0] wr_len(input logic [7:0] c);
    if (c == CMD_OP) return 3'h1;
    if (c == CMD_CLR) return 3'h0;
    if (c == CMD_VOUT || c == CMD_OVLIM) return 3'h2;
    if (c == CMD_FANSET) return 3'h3;
    if (c >= CMD_MFR_LO && c <= CMD_MFR_HI && c != CMD_VIN && c != CMD_FWREV &&
        c != CMD_RUNT && c != CMD_FAN) return 3'h0;
    return WL_BAD;
  endfunction

  // read payload length, zero when not readable
  function automatic logic [4:0] rd_len(input logic [7:0] c);
    case (c)
      CMD_STAT:  return 5'h0a;
      CMD_VIN:   return 5'h02;
      CMD_FWREV: return 5'h03;
      CMD_RUNT:  return 5'h03;
      CMD_FAN:   return 5'h04;
      default:   return 5'h00;
    endcase
  endfunction

  function automatic logic [4:0] rd_base(input logic [7:0] c);
    case (c)
      CMD_VIN:   return SN_VIN;
      CMD_FWREV: return SN_FW;
      CMD_RUNT:  return SN_RUNT;
      CMD_FAN:   return SN_FAN;
      default:   return SN_STAT;
    endcase
  endfunction
endpackage

// ### dv/psci_cmd_interp_assertions.sv
/* port checker for psci_cmd_interp, bound to every instance.
   assumes OFF_CYCLES equals the bound instance's value */
`timescale 1ns/100ps
module psci_cmd_interp_assertions #(
  parameter longint OFF_CYCLES = psci_pkg::OFF_CYC
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        link_clk,
  input wire logic        scl_in,
  input wire logic        sda_oe,
  input wire logic        enable_n,
  input wire logic        output_on,
  input wire logic [15:0] vout_set,
  input wire logic        vout_bus_ctl,
  input wire logic        restart_clr,
  input wire logic        mfr_stb,
  input wire logic [7:0]  mfr_code
);
  logic   on_q;
  longint off_run;
  // length of the last off period, held while on
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_q    <= 1'h0;
      off_run <= 0;
    end else begin
      on_q <= output_on;
      if (!output_on) off_run <= on_q ? 1 : off_run + 1;
    end
  end
  sequence rise_on;
    !output_on ##1 output_on;
  endsequence
  sequence stb_gone;
    !mfr_stb && $stable(mfr_code);
  endsequence
  bus_ctl_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    vout_bus_ctl |=> vout_bus_ctl) else $error("set point ownership dropped");
  vset_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(vout_set) |-> vout_set inside {[psci_pkg::VOUT_MIN_CODE:psci_pkg::VOUT_MAX_CODE]})
    else $error("set point outside range");
  vset_owner_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(vout_set) |=> vout_bus_ctl) else $error("set point changed without bus control");
  restart_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    restart_clr |-> off_run >= OFF_CYCLES - 1) else $error("restart after short off");
  restart_due_a: assert property (@(posedge clk) disable iff (sys_rst)
    rise_on ##0 (off_run >= OFF_CYCLES + 2) |-> ##[0:4] restart_clr)
    else $error("restart missing after long off");
  restart_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    restart_clr |-> output_on ##1 !restart_clr) else $error("restart pulse malformed");
  mfr_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    mfr_stb |=> stb_gone ##0 mfr_code inside {[8'hd2:8'he2]} &&
    !(mfr_code inside {8'hdc, 8'hdd, 8'hde, 8'he1})) else $error("bad maker strobe");
  enable_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    enable_n [*5] |-> !output_on) else $error("output on while disabled");
  ack_hold_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    scl_in [*3] |-> $stable(sda_oe)) else $error("sda drive moved with scl high");
endmodule // psci_cmd_interp_assertions
bind psci_cmd_interp psci_cmd_interp_assertions #(.OFF_CYCLES(OFF_CYCLES)) chk_i (.*);

// ### dv/psci_host_model.sv
/* host model: bit-banged bus master, sda pulled up when released.
   assumes the device pulls sda low while sda_oe is high */
`timescale 1ns/100ps
module psci_host_model (
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic host_low = 1'h0;
  initial scl_in = 1'h1;
  // wired-and with pull-up; scl idles high
  assign sda_in = !(host_low || sda_oe);
  // data moves only while scl low
  task automatic bit_c(input logic b, output logic r);
    #20 host_low = !b;
    #70 scl_in = 1'h1;
    #20 r = sda_in;
    #20 scl_in = 1'h0;
  endtask
  // start, long low lets the slave release
  task automatic start_c;
    #20 host_low = 1'h0;
    #90 scl_in = 1'h1;
    #40 host_low = 1'h1;
    #40 scl_in = 1'h0;
  endtask
  task automatic stop_c;
    #20 host_low = 1'h1;
    #90 scl_in = 1'h1;
    #40 host_low = 1'h0;
    #40;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(b[i], r);
    bit_c(1'h1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(1'h1, b[i]);
    bit_c(last, r);
  endtask
endmodule // psci_host_model

// ### dv/psci_cmd_interp_bench.sv
/* bench for psci_cmd_interp: table of writes checked by status reads,
   then hand tests. assumes the host model and the bound checker */
`timescale 1ns/100ps
module psci_cmd_interp_bench;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  c;
    logic [1:0]  n;
    logic        bad;
    logic [15:0] d;
    logic [15:0] v;
    logic [15:0] o;
    logic [7:0]  s;
  } psci_row_t;
  logic        clk = 1'h0, link_clk = 1'h0, sys_rst = 1'h1, enable_n = 1'h0;
  logic        high_line = 1'h0, restart_pend = 1'h0, iso_done = 1'h0, iso_pass = 1'h0;
  logic        scl_in, sda_in, sda_out, sda_oe, ack, alert_out_n, output_on;
  logic        vout_bus_ctl, restart_clr, mfr_stb, rs_seen = 1'h0;
  logic [2:0]  addr_sel = 3'h5;
  logic [7:0]  status1_in = 8'h00, alarm1_in = 8'h00, alarm2_in = 8'h00;
  logic [7:0]  pin_meas = 8'h21, fan_pct = 8'h3c, mfr_code, pec, rb [0:15];
  logic [8:0]  vin_volts = 9'h12c;
  logic [15:0] vout_meas = 16'h4ed4, iout_amps = 16'h0010, temp_c = 16'h0019;
  logic [15:0] fan_rpm = 16'h300c, vout_set, overvoltage_limit_cmd;
  logic [23:0] fw_rev = 24'h010203, run_time = 24'h000100;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  // bounds, broadcast, bad pec, unknown, clear
  psci_row_t rows [0:7] = '{
    '{8'h8a, 8'h21, 2'h2, 1'h0, 16'h4ed4, 16'h4ed4, 16'h0000, 8'h00},
    '{8'h8a, 8'h21, 2'h2, 1'h0, 16'h419f, 16'h4ed4, 16'h0000, 8'h02},
    '{8'h00, 8'h21, 2'h2, 1'h0, 16'h5aa0, 16'h5aa0, 16'h0000, 8'h00},
    '{8'h8a, 8'h40, 2'h2, 1'h0, 16'h5dc0, 16'h5aa0, 16'h5dc0, 8'h00},
    '{8'h8a, 8'h21, 2'h2, 1'h1, 16'h41a0, 16'h5aa0, 16'h5dc0, 8'h80},
    '{8'h8a, 8'h55, 2'h0, 1'h0, 16'h0000, 16'h5aa0, 16'h5dc0, 8'ha0},
    '{8'h8a, 8'h03, 2'h0, 1'h0, 16'h0000, 16'h5aa0, 16'h5dc0, 8'h00},
    '{8'h8a, 8'h21, 2'h2, 1'h0, 16'h41a0, 16'h41a0, 16'h5dc0, 8'h00}};
  // short restart count keeps the run brief
  psci_cmd_interp #(.OFF_CYCLES(3000)) dut (.*);
  psci_host_model host (.*);
  initial forever #2.5 clk = ~clk;
  // link clock, phase unrelated to clk
  initial begin
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    repeat (8) r = r[7] ? {r[6:0], 1'h0} ^ 8'h07 : {r[6:0], 1'h0};
    return r;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // write frame, low byte first, pec over address
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [1:0] n,
                    input logic [15:0] d, input logic bad);
    logic [7:0] p;
    p = crc(crc(8'h00, a), c);
    host.start_c();
    host.put(a, ack);
    chk(ack, 1'h1, "addr_ack");
    host.put(c, ack);
    for (int i = 0; i < n; i++) begin
      host.put(d[8*i +: 8], ack);
      p = crc(p, d[8*i +: 8]);
    end
    host.put(p ^ {7'h00, bad}, ack);
    host.stop_c();
    repeat (20) @(negedge clk);
  endtask
  // block read, count then data then pec; the vin read has no count
  task automatic rd(input logic [7:0] c);
    logic [7:0] p;
    host.start_c();
    host.put(8'h8a, ack);
    host.put(c, ack);
    host.start_c();
    host.put(8'h8b, ack);
    host.get(1'h0, rb[0]);
    p = crc(crc(crc(crc(8'h00, 8'h8a), c), 8'h8b), rb[0]);
    for (int i = 1; i <= (c == 8'hdc ? 8'h01 : rb[0]) && i < 16; i++) begin
      host.get(1'h0, rb[i]);
      p = crc(p, rb[i]);
    end
    host.get(1'h1, pec);
    host.stop_c();
    chk(pec, p, "read_pec");
    repeat (20) @(negedge clk);
  endtask
  // cycle ceiling and restart pulse capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (restart_clr) rs_seen <= 1'h1;
    if (cyc == 95000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    chk(output_on, 1'h0, "on_in_reset");
    sys_rst = 1'h0;
    repeat (20) @(negedge clk);
    chk(output_on, 1'h1, "on_at_powerup");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].c, rows[i].n, rows[i].d, rows[i].bad);
      chk(vout_set, rows[i].v, "vout_set");
      chk(overvoltage_limit_cmd, rows[i].o, "ov_limit");
      rd(8'hd0);
      chk(rb[0], 8'h0a, "status_count");
      chk(rb[2], rows[i].s, "status2");
    end
    wr(8'h8a, 8'h7f, 2'h0, 16'h0000, 1'h0);
    chk(alert_out_n, 1'h0, "alert_bad_cmd");
    rd(8'hd0);
    chk(alert_out_n, 1'h1, "alert_released");
    chk({rb[6], rb[5]}, 16'h4ed4, "vout_bytes");
    chk({rb[8], rb[7]}, 16'h0050, "iout_bytes");
    rd(8'hdc);
    chk({rb[0], rb[1]}, 16'he121, "vin_pin");
    wr(8'h8a, 8'h03, 2'h0, 16'h0000, 1'h0);
    rd(8'he1);
    chk(rb[0], 8'h04, "fan_count");
    chk({rb[1], rb[3]}, 16'h3c7b, "fan_read");
    wr(8'h8a, 8'hda, 2'h0, 16'h0000, 1'h0);
    chk(mfr_code, 8'hda, "maker_code");
    wr(8'h8a, 8'h01, 2'h1, 16'h0000, 1'h0);
    chk(output_on, 1'h0, "op_off");
    wr(8'h8a, 8'h01, 2'h1, 16'h0080, 1'h0);
    chk({output_on, rs_seen}, 2'h2, "short_off");
    wr(8'h8a, 8'h01, 2'h1, 16'h0000, 1'h0);
    repeat (3000) @(negedge clk);
    wr(8'h8a, 8'h01, 2'h1, 16'h0080, 1'h0);
    chk({output_on, rs_seen}, 2'h3, "long_off");
    iso_done = 1'h1;
    @(negedge clk);
    iso_done = 1'h0;
    rd(8'hd0);
    chk({rb[2][3:2], rb[1][5]}, 3'h6, "iso_fail");
    enable_n = 1'h1;
    high_line = 1'h1;
    alarm1_in = 8'h01;
    repeat (10) @(negedge clk);
    chk({output_on, alert_out_n}, 2'h0, "disable_alert");
    rd(8'hd0);
    chk(rb[2] & 8'h11, 8'h11, "status2_pins");
    tally_and_finish();
  end
endmodule // psci_cmd_interp_bench
